// >>> rtl/camsk_cmp.sv
/*
 Combinational acceptance compare of one identifier against one filter
 under one mask. Assumes inputs stable for the cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module camsk_cmp
(
   camsk_cmp_if.cmp c
);
   logic sid_ok;
   logic eid_ok;
   logic type_ok;

   always_comb
   begin
      // Cleared mask bits are don't care
      sid_ok = ((c.rx.std_id_mask_bits ^ c.filt.std_id_mask_bits) & c.sid_mask) == '0;
      eid_ok = ((c.rx.ext_id_mask_bits ^ c.filt.ext_id_mask_bits) & c.eid_mask) == '0;
      // Frame format must agree only in strict mode
      type_ok = !c.id_type_match_mode || (c.rx.ext == c.filt.ext);
      // Standard frames carry no extended bits to compare
      c.pass = type_ok && sid_ok && (eid_ok || !c.rx.ext);
   end
endmodule
`default_nettype wire

// >>> rtl/camsk_cmp_if.sv
/*
 Carries mask, filter and received identifier to the compare unit
 and the verdict back. Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface camsk_cmp_if;
   camsk_pkg::camsk_sid_t sid_mask;
   camsk_pkg::camsk_eid_t eid_mask;
   logic id_type_match_mode;
   camsk_pkg::camsk_id_t filt;
   camsk_pkg::camsk_id_t rx;
   logic pass;
   modport top (output sid_mask, eid_mask, id_type_match_mode, filt, rx,
      input pass);
   modport cmp (input sid_mask, eid_mask, id_type_match_mode, filt, rx,
      output pass);
endinterface
`default_nettype wire

// >>> rtl/camsk_pkg.sv
/*
 Types shared by the mask block and its compare unit.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package camsk_pkg;
   typedef logic [10:0] camsk_sid_t;
   typedef logic [17:0] camsk_eid_t;
   typedef struct packed {
      logic ext;
      camsk_sid_t std_id_mask_bits;
      camsk_eid_t ext_id_mask_bits;
   } camsk_id_t;
endpackage

// >>> rtl/camsk_regs.svh
/*
 Register offsets, field positions and reset values of the CAN
 acceptance mask block. Assumes a 32-bit APB with byte addresses.
*/
`ifndef CAMSK_REGS_SVH
`define CAMSK_REGS_SVH

`define CAMSK_OFF_MASK_STD 12'h000
`define CAMSK_OFF_MASK_EXT 12'h004
`define CAMSK_OFF_FILTER 12'h008
`define CAMSK_OFF_RX_ID 12'h00c
`define CAMSK_OFF_STATUS 12'h010

`define CAMSK_SID_HI 15
`define CAMSK_SID_LO 5
`define CAMSK_MODE_BIT 3
`define CAMSK_EID_HI_HI 1
`define CAMSK_EID_HI_LO 0
`define CAMSK_STD_WMASK 16'hffeb
`define CAMSK_STD_RST 16'h0000
`define CAMSK_EXT_RST 16'h0000
`define CAMSK_FLT_RST 32'h00000000

`endif

// >>> rtl/camsk_top.sv
/*
 APB slave holding one CAN acceptance mask (standard half and extended
 half), one filter and a received identifier, with the verdict shown
 in a status register. Assumes a 32-bit APB master on pclk.
*/
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "camsk_regs.svh"

module camsk_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic accept
);
   ////////////////////////////////////////////////////////////////////
   camsk_cmp_if cif ();

   logic [15:0] std_q, std_d;
   logic [15:0] ext_q, ext_d;
   logic [31:0] flt_q, flt_d;
   logic [31:0] rxid_q, rxid_d;
   logic acc_q, acc_d;
   logic [31:0] rdata_q, rdata_d;
   logic wr_en, rd_en, hit;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign pready = 1'b1;

   always_comb
   begin
      hit = (paddr == `CAMSK_OFF_MASK_STD) ||
            (paddr == `CAMSK_OFF_MASK_EXT) ||
            (paddr == `CAMSK_OFF_FILTER) ||
            (paddr == `CAMSK_OFF_RX_ID) ||
            (paddr == `CAMSK_OFF_STATUS);
      pslverr = psel && penable && !hit;
   end

   ////////////////////////////////////////////////////////////////////
   always_comb
   begin
      std_d = std_q;
      ext_d = ext_q;
      flt_d = flt_q;
      rxid_d = rxid_q;
      if (wr_en)
      begin
         case (paddr)
            // Unimplemented positions never store
            `CAMSK_OFF_MASK_STD: std_d = pwdata[15:0] & `CAMSK_STD_WMASK;
            `CAMSK_OFF_MASK_EXT: ext_d = pwdata[15:0];
            `CAMSK_OFF_FILTER: flt_d = pwdata;
            `CAMSK_OFF_RX_ID: rxid_d = pwdata;
            default: ;
         endcase
      end
   end

   // Read data captured in setup so it is stable through access
   always_comb
   begin
      rdata_d = rdata_q;
      if (rd_en)
      begin
         case (paddr)
            `CAMSK_OFF_MASK_STD: rdata_d = {16'h0000, std_q};
            `CAMSK_OFF_MASK_EXT: rdata_d = {16'h0000, ext_q};
            `CAMSK_OFF_FILTER: rdata_d = flt_q;
            `CAMSK_OFF_RX_ID: rdata_d = rxid_q;
            `CAMSK_OFF_STATUS: rdata_d = {31'h00000000, acc_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Id word layout: bit 31 extended flag, 28:18 sid, 17:0 eid
   always_comb
   begin
      cif.sid_mask = std_q[`CAMSK_SID_HI:`CAMSK_SID_LO];
      cif.eid_mask = {std_q[`CAMSK_EID_HI_HI:`CAMSK_EID_HI_LO],
                      ext_q};
      cif.id_type_match_mode = std_q[`CAMSK_MODE_BIT];
      cif.filt = {flt_q[31], flt_q[28:18], flt_q[17:0]};
      cif.rx = {rxid_q[31], rxid_q[28:18], rxid_q[17:0]};
      acc_d = cif.pass;
   end

   camsk_cmp u_cmp
   (
      .c(cif)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         std_q <= `CAMSK_STD_RST;
         ext_q <= `CAMSK_EXT_RST;
         flt_q <= `CAMSK_FLT_RST;
         rxid_q <= `CAMSK_FLT_RST;
         acc_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         std_q <= std_d;
         ext_q <= ext_d;
         flt_q <= flt_d;
         rxid_q <= rxid_d;
         acc_q <= acc_d;
         rdata_q <= rdata_d;
      end
   end

   assign prdata = rdata_q;
   assign accept = acc_q;

   ////////////////////////////////////////////////////////////////////
   // Verdict checks recompute the compare from the raw registers, so a
   // wiring slip between the registers and the compare unit shows up
   chk_unimpl_zero: assert property (@(posedge pclk)
      disable iff (!presetn)
      std_q[4] == 1'b0 && std_q[2] == 1'b0)
      else $error("unimplemented mask bit stored");

   chk_masked_ignored: assert property (@(posedge pclk)
      disable iff (!presetn)
      (std_q[15:5] == 11'h000 && std_q[3] == 1'b0 &&
       std_q[1:0] == 2'h0 && ext_q == 16'h0000) |=> accept)
      else $error("all-clear mask must accept");

   chk_mode_strict: assert property (@(posedge pclk)
      disable iff (!presetn)
      (std_q[3] && rxid_q[31] != flt_q[31]) |=> !accept)
      else $error("format mismatch accepted in strict mode");

   chk_exact_match: assert property (@(posedge pclk)
      disable iff (!presetn)
      (rxid_q == flt_q) |=> accept)
      else $error("identical id rejected");

   chk_std_frame_eid: assert property (@(posedge pclk)
      disable iff (!presetn)
      (!rxid_q[31] && !std_q[3] &&
       ((rxid_q[28:18] ^ flt_q[28:18]) & std_q[15:5]) == 11'h000)
      |=> accept)
      else $error("standard frame rejected on extended bits");

   chk_sid_included: assert property (@(posedge pclk)
      disable iff (!presetn)
      (((rxid_q[28:18] ^ flt_q[28:18]) & std_q[15:5]) != 11'h000)
      |=> !accept)
      else $error("masked sid mismatch accepted");

   chk_all_match_pass: assert property (@(posedge pclk)
      disable iff (!presetn)
      ((!std_q[3] || rxid_q[31] == flt_q[31]) &&
       ((rxid_q[28:18] ^ flt_q[28:18]) & std_q[15:5]) == 11'h000 &&
       (!rxid_q[31] ||
        ((rxid_q[17:0] ^ flt_q[17:0]) & {std_q[1:0], ext_q}) == 18'h00000))
      |=> accept)
      else $error("fully matching id rejected");

   chk_eid_top: assert property (@(posedge pclk)
      disable iff (!presetn)
      (rxid_q[31] && ((rxid_q[17:16] ^ flt_q[17:16]) & std_q[1:0]) != 2'h0)
      |=> !accept)
      else $error("masked eid top mismatch accepted");

   chk_eid_low: assert property (@(posedge pclk)
      disable iff (!presetn)
      (rxid_q[31] && ((rxid_q[15:0] ^ flt_q[15:0]) & ext_q) != 16'h0000)
      |=> !accept)
      else $error("masked eid low mismatch accepted");

   chk_std_write: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr_en && paddr == `CAMSK_OFF_MASK_STD)
      |=> std_q == ($past(pwdata[15:0]) & `CAMSK_STD_WMASK))
      else $error("mask write not stored");

   // A read is a setup edge that captures the word, then the access
   // edge at which the master takes it
   sequence camsk_std_rd_setup;
      rd_en && paddr == `CAMSK_OFF_MASK_STD;
   endsequence

   sequence camsk_ext_rd_setup;
      rd_en && paddr == `CAMSK_OFF_MASK_EXT;
   endsequence

   sequence camsk_rd_access;
      psel && penable && !pwrite && pready;
   endsequence

   chk_std_read_zero: assert property (@(posedge pclk)
      disable iff (!presetn)
      camsk_std_rd_setup ##1 camsk_rd_access
      |-> prdata[31:16] == 16'h0000 && prdata[4] == 1'b0 &&
          prdata[2] == 1'b0)
      else $error("unimplemented mask bit read as one");

   chk_ext_read_back: assert property (@(posedge pclk)
      disable iff (!presetn)
      camsk_ext_rd_setup ##1 camsk_rd_access
      |-> prdata == {16'h0000, ext_q})
      else $error("companion mask read back wrong");
endmodule
`default_nettype wire

// >>> tb/camsk_can_node.sv
/*
 Far-side node: shapes a raw word into a received identifier word.
 Assumes the bench writes that word into the receive id register.
*/
`timescale 1ns/1ps
`default_nettype none
module camsk_can_node
(
   input wire logic [31:0] seed,
   input wire logic ext,
   output logic [31:0] id_word
);
   // A standard frame has no extended bits, so junk stands there
   assign id_word = {ext, 2'h0, seed[28:18],
      ext ? seed[17:0] : ~seed[17:0]};
endmodule
`default_nettype wire

// >>> tb/test_can_acceptance_mask_std_id.sv
/*
 Self-checking bench of the acceptance mask block over APB.
 Assumes the block's register map and its id word layout.
*/
`timescale 1ns/1ps
`default_nettype none
`include "camsk_regs.svh"
module test_can_acceptance_mask_std_id;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h42, rx;
   logic pready, pslverr, accept, err, ext = 0;
   int fails = 0, checks = 0;
   camsk_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .accept(accept));
   camsk_can_node node (.seed(seed), .ext(ext), .id_word(rx));
   always #5 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
   endfunction
   function automatic logic exp_acc(input logic [31:0] m, me, f, r);
      logic [17:0] em;
      em = {m[1:0], me[15:0]};
      if (m[3] && f[31] != r[31])
         return 1'b0;
      if (((f[28:18] ^ r[28:18]) & m[15:5]) != 11'h0)
         return 1'b0;
      return !r[31] || ((f[17:0] ^ r[17:0]) & em) == 18'h0;
   endfunction
   task automatic report_and_stop;
      if (fails == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, e);
      checks++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Holds the request until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (pready !== 1'b1)
      begin
         fails++;
         report_and_stop();
      end
      // One idle edge so that no signal is driven twice in a time step
      @(posedge pclk);
   endtask
   task automatic trial(input logic [31:0] m, me, f);
      apb(1, `CAMSK_OFF_MASK_STD, m);
      apb(1, `CAMSK_OFF_MASK_EXT, me);
      apb(1, `CAMSK_OFF_FILTER, f);
      apb(1, `CAMSK_OFF_RX_ID, rx);
      repeat (2) @(posedge pclk);
      chk({31'h0, accept}, {31'h0, exp_acc(m, me, f, rx)});
      apb(0, `CAMSK_OFF_STATUS, 32'h0);
      chk(rd, {31'h0, exp_acc(m, me, f, rx)});
      apb(0, `CAMSK_OFF_MASK_STD, 32'h0);
      chk(rd, {16'h0, m[15:0] & `CAMSK_STD_WMASK});
      apb(0, `CAMSK_OFF_MASK_EXT, 32'h0);
      chk(rd, {16'h0, me[15:0]});
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(1, `CAMSK_OFF_MASK_STD, 32'hffffffff);
      apb(0, `CAMSK_OFF_MASK_STD, 32'h0);
      chk(rd, 32'h0000ffeb);
      apb(0, 12'h0fc, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      // Every mode, filter format and frame format with open masks
      for (int i = 0; i < 8; i++)
      begin
         ext <= i[0];
         trial({28'h0, i[2], 3'h0}, 32'h0, {i[1], 31'h0});
      end
      for (int i = 0; i < 60; i++)
      begin
         seed <= lfsr(seed);
         ext <= seed[3];
         @(posedge pclk);
         // Filter mostly copies the id so that passes are common
         trial(seed ^ 32'h5a5a, lfsr(seed), {seed[5], 2'h0,
            seed[28:18] ^ {10'h0, seed[6]}, seed[17:0] ^ {17'h0, seed[7]}});
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
